// *** sew_pkg.sv ***
// Constants for the two-wire serial memory slave front end.
// Assumes a 250 MHz core clock; the link pins are sampled by that clock.
package sew_pkg;
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned PROG_TIME_US     = 5000;
    localparam int unsigned PROG_CYCLES      = PROG_TIME_US * CLK_MHZ;
    localparam int unsigned MEM_DEPTH        = 1024;
    localparam int unsigned ADDR_W           = 10;
    localparam int unsigned PAGE_BYTES       = 16;
    localparam int unsigned PAGE_W           = 4;
    localparam logic [3:0]  DEV_TYPE         = 4'ha;
    localparam int unsigned SA_TYPE_HI       = 7;
    localparam int unsigned SA_TYPE_LO       = 4;
    localparam int unsigned SA_STRAP_BIT     = 3;
    localparam int unsigned SA_BLK_HI_BIT    = 2;
    localparam int unsigned SA_BLK_LO_BIT    = 1;
    localparam int unsigned SA_RW_BIT        = 0;
    localparam int unsigned FIFO_DEPTH       = 32;
    localparam int unsigned FIFO_AW          = 5;
    localparam logic [7:0]  MEM_RESET_VALUE  = 8'hff;

    typedef enum logic [2:0]
    {
        SEW_IDLE  = 3'b000,
        SEW_ADDR  = 3'b001,
        SEW_WORD  = 3'b010,
        SEW_WDATA = 3'b011,
        SEW_RDATA = 3'b100,
        SEW_IGN   = 3'b101
    } sew_state_t;
endpackage

// *** sew_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Single clock; full and empty come from a count.
`timescale 1ns/100ps
module sew_fifo
#(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 32,
    parameter int unsigned AW    = 5
)
(
    input  wire logic             core_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH)) && !flush_i;
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];

    always_ff @(posedge core_clk_i)
    begin
        if (push)
            mem_q[wr_q] <= in_data_i;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else if (flush_i)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// *** sew_slave.sv ***
// Two-wire serial memory slave: bus front end, page buffer and self-timed programming.
// Assumes a bus master drives the serial clock; reset_n_i is the power-on reset.
`timescale 1ns/100ps
module sew_slave
#(
    parameter int unsigned PROG_CYCLES = sew_pkg::PROG_CYCLES
)
(
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    input  wire logic device_select_strap_i,
    input  wire logic write_protect_i,
    output logic      busy_o,
    output logic      standby_o
);
    localparam int unsigned AW = sew_pkg::ADDR_W;
    localparam int unsigned FW = AW + 8;

    // Two-flop synchronisers for all pins
    logic [1:0] scl_s_q, sda_s_q, strap_s_q, wp_s_q;
    logic       scl_q, sda_q;

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scl_s_q   <= 2'h3;
            sda_s_q   <= 2'h3;
            strap_s_q <= 2'h0;
            wp_s_q    <= 2'h0;
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
        end
        else
        begin
            scl_s_q   <= {scl_s_q[0], scl_i};
            sda_s_q   <= {sda_s_q[0], sda_i};
            strap_s_q <= {strap_s_q[0], device_select_strap_i};
            wp_s_q    <= {wp_s_q[0], write_protect_i};
            scl_q     <= scl_s_q[1];
            sda_q     <= sda_s_q[1];
        end
    end

    wire scl    = scl_s_q[1];
    wire sda    = sda_s_q[1];
    wire strap  = strap_s_q[1];  // Floating pulled low at pad
    wire wp     = wp_s_q[1];
    wire scl_rise = scl && !scl_q;
    wire scl_fall = !scl && scl_q;
    wire start_c  = scl && scl_q && sda_q && !sda;
    wire stop_c   = scl && scl_q && !sda_q && sda;

    sew_pkg::sew_state_t state_q;
    logic [7:0]    shift_q;
    logic [3:0]    bit_q;
    logic          ack_phase_q;
    logic          drive_low_q;
    logic          rd_q;
    logic [AW-1:0] addr_q;
    logic          loaded_q;
    logic          prog_q;
    logic [22:0]   prog_cnt_q;
    logic [7:0]    mem_q [sew_pkg::MEM_DEPTH];
    logic [7:0]    rdata_q;

    // FIFO carries loaded page bytes to the programmer
    logic          fifo_in_valid;
    logic          fifo_in_ready;
    logic [FW-1:0] fifo_out_data;
    logic          fifo_out_valid;
    logic          fifo_out_ready;
    logic          fifo_flush;

    wire byte_done   = scl_rise && (bit_q == 4'h7) && !ack_phase_q;
    wire [7:0] rx    = {shift_q[6:0], sda};
    wire addr_match  = (rx[sew_pkg::SA_TYPE_HI:sew_pkg::SA_TYPE_LO] == sew_pkg::DEV_TYPE)
                       && (rx[sew_pkg::SA_STRAP_BIT] == strap);
    wire addr_ack    = addr_match && !prog_q;
    wire data_ack    = fifo_in_ready;
    wire store_byte  = byte_done && (state_q == sew_pkg::SEW_WDATA) && data_ack;
    wire commit      = stop_c && loaded_q && !prog_q && !wp;
    wire discard     = stop_c && loaded_q && wp;

    assign fifo_in_valid  = store_byte;
    assign fifo_out_ready = prog_q && (prog_cnt_q == 23'h0);
    assign fifo_flush     = discard;

    sew_fifo
    #(
        .WIDTH (FW),
        .DEPTH (sew_pkg::FIFO_DEPTH),
        .AW    (sew_pkg::FIFO_AW)
    )
    u_fifo
    (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .flush_i     (fifo_flush),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({addr_q, rx}),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    // Bit engine and protocol state machine
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q     <= sew_pkg::SEW_IDLE;
            shift_q     <= 8'h00;
            bit_q       <= 4'h0;
            ack_phase_q <= 1'b0;
            drive_low_q <= 1'b0;
            rd_q        <= 1'b0;
            addr_q      <= '0;
            loaded_q    <= 1'b0;
        end
        else if (start_c)
        begin
            state_q     <= sew_pkg::SEW_ADDR;
            bit_q       <= 4'h0;
            ack_phase_q <= 1'b0;
            drive_low_q <= 1'b0;
        end
        else if (stop_c)
        begin
            state_q     <= sew_pkg::SEW_IDLE;
            drive_low_q <= 1'b0;
            loaded_q    <= 1'b0;
        end
        else if (state_q != sew_pkg::SEW_IDLE && state_q != sew_pkg::SEW_IGN)
        begin
            if (scl_rise && !ack_phase_q)
            begin
                shift_q <= rx;
                bit_q   <= bit_q + 4'h1;
            end
            if (byte_done)
            begin
                ack_phase_q <= 1'b1;
                case (state_q)
                    sew_pkg::SEW_ADDR:
                    begin
                        rd_q <= rx[sew_pkg::SA_RW_BIT];
                        addr_q[AW-1:AW-2] <= {rx[sew_pkg::SA_BLK_HI_BIT], rx[sew_pkg::SA_BLK_LO_BIT]};
                        if (!addr_ack)
                            state_q <= sew_pkg::SEW_IGN;
                        else if (rx[sew_pkg::SA_RW_BIT])
                            state_q <= sew_pkg::SEW_RDATA;
                        else
                            state_q <= sew_pkg::SEW_WORD;
                    end
                    sew_pkg::SEW_WORD:
                    begin
                        addr_q[7:0] <= rx;
                        state_q     <= sew_pkg::SEW_WDATA;
                    end
                    sew_pkg::SEW_WDATA:
                    begin
                        if (data_ack)
                        begin
                            loaded_q <= 1'b1;
                            addr_q[sew_pkg::PAGE_W-1:0] <= addr_q[sew_pkg::PAGE_W-1:0] + 4'h1;
                        end
                    end
                    default:
                    begin
                        state_q <= state_q;
                    end
                endcase
            end
            if (scl_fall && bit_q == 4'h8 && !ack_phase_q && state_q == sew_pkg::SEW_RDATA && !rd_q)
                drive_low_q <= 1'b0;
            if (scl_fall && ack_phase_q)
            begin
                if (bit_q == 4'h8)
                begin
                    // Drive ack unless the slave address was refused; data bytes are acked even when the FIFO is full
                    drive_low_q <= (state_q != sew_pkg::SEW_IGN);
                    bit_q       <= 4'h9;
                end
                else
                begin
                    drive_low_q <= 1'b0;
                    ack_phase_q <= 1'b0;
                    bit_q       <= 4'h0;
                end
            end
        end
    end

    // Self-timed programming; array written one byte at a time from the FIFO
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            prog_q     <= 1'b0;
            prog_cnt_q <= 23'h0;
        end
        else if (commit)
        begin
            prog_q     <= 1'b1;
            // Room for a full FIFO drain plus the final empty check
            prog_cnt_q <= 23'(PROG_CYCLES - sew_pkg::FIFO_DEPTH - 1);
        end
        else if (prog_q)
        begin
            if (prog_cnt_q != 23'h0)
                prog_cnt_q <= prog_cnt_q - 23'h1;
            else if (!fifo_out_valid)
                prog_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (fifo_out_valid && fifo_out_ready && !wp)
            mem_q[fifo_out_data[FW-1:8]] <= fifo_out_data[7:0];
        rdata_q <= mem_q[addr_q];
    end

    assign sda_o     = 1'b0;
    assign sda_oe_o  = drive_low_q;
    assign busy_o    = prog_q;
    assign standby_o = (state_q == sew_pkg::SEW_IDLE) && !prog_q;
endmodule

// *** sew_slave_sva.sv ***
// Checker for the two-wire slave: ack, programming and standby timing.
// Sees only the slave's ports; bound to every slave instance below.
`timescale 1ns/100ps
module sew_slave_sva
#(
    parameter int unsigned PROG_CYCLES = 2000
)
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic device_select_strap_i,
    input wire logic write_protect_i,
    input wire logic busy_o,
    input wire logic standby_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    int unsigned busy_cnt_q;
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            busy_cnt_q <= 0;
        else
            busy_cnt_q <= busy_o ? busy_cnt_q + 1 : 0;
    end
    open_drain_a: assert property (sda_o == 1'b0) else $error("data driven high");
    reset_idle_a: assert property ($rose(reset_n_i) |-> standby_o && !busy_o) else $error("not idle");
    prog_bound_a: assert property (busy_o |-> busy_cnt_q < PROG_CYCLES) else $error("prog too long");
    prog_hold_a: assert property ($rose(busy_o) |-> busy_o[*8]) else $error("prog cut short");
    no_busy_ack_a: assert property (busy_o |-> !sda_oe_o) else $error("ack while busy");
    wp_no_prog_a: assert property ($rose(busy_o) |-> !write_protect_i) else $error("prog under wp");
    standby_after_a: assert property ($fell(busy_o) |-> ##[0:2] standby_o) else $error("no standby");
    busy_not_idle_a: assert property (busy_o || sda_oe_o |-> !standby_o) else $error("standby early");
    ack_scl_low_a: assert property ($rose(sda_oe_o) |-> !scl_i) else $error("ack on clock high");
    ack_release_a: assert property ($rose(sda_oe_o) |-> ##[20:60] !sda_oe_o) else $error("ack held");
    cover property ($rose(busy_o));
    cover property ($fell(busy_o));
    cover property ($rose(sda_oe_o));
    cover property ($rose(standby_o));
endmodule

bind sew_slave sew_slave_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva
(
    .core_clk_i            (core_clk_i),
    .reset_n_i             (reset_n_i),
    .scl_i                 (scl_i),
    .sda_i                 (sda_i),
    .sda_o                 (sda_o),
    .sda_oe_o              (sda_oe_o),
    .device_select_strap_i (device_select_strap_i),
    .write_protect_i       (write_protect_i),
    .busy_o                (busy_o),
    .standby_o             (standby_o)
);

// *** sew_master_model.sv ***
// Two-wire bus master model: start, stop, byte send with ack sampling.
// Assumes a pull-up on the data line outside; clock stays high between frames.
`timescale 1ns/100ps
module sew_master_model
(
    input  wire logic core_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // Quarter bit of 40 ns, so one bit is 160 ns
    task automatic q(input int n);
        repeat (10 * n) @(posedge core_clk_i);
    endtask
    task automatic start;
        @(posedge core_clk_i);
        sda_low_o <= 1'b1;
        q(2);
        scl_o <= 1'b0;
        q(1);
    endtask
    task automatic stop;
        sda_low_o <= 1'b1;
        q(1);
        scl_o <= 1'b1;
        q(2);
        sda_low_o <= 1'b0;
        q(2);
    endtask
    // Data only changes a quarter bit away from either clock edge
    task automatic bit_cycle(input logic pull, output logic seen);
        sda_low_o <= pull;
        q(1);
        scl_o <= 1'b1;
        q(1);
        seen = sda_i;
        q(1);
        scl_o <= 1'b0;
        q(1);
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(!b[i], s);
        bit_cycle(1'b0, s);
        ack = (s === 1'b0);
    endtask
endmodule

// *** tb_top.sv ***
// Bench for the two-wire slave: page write, polling, addressing, protect, reset.
// Uses the master model; programming time shortened to PROG cycles.
`timescale 1ns/100ps
module tb_top;
    localparam int PROG = 2000;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic strap = 1'b0;
    logic wp = 1'b0;
    logic scl;
    logic sda_low;
    logic sda_o;
    logic sda_oe;
    logic busy;
    logic standby;
    wire sda_line = sda_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    always #2 core_clk = ~core_clk;
    sew_slave #(.PROG_CYCLES(PROG)) u_dut (.core_clk_i(core_clk), .reset_n_i(reset_n), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe), .device_select_strap_i(strap),
        .write_protect_i(wp), .busy_o(busy), .standby_o(standby));
    sew_master_model u_master (.core_clk_i(core_clk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    // n < 0: slave byte only; else word address and n data bytes
    task automatic frame(input logic [7:0] sa, input int n, output int acks);
        logic a;
        u_master.start();
        u_master.send(sa, a);
        acks = int'(a);
        for (int i = -1; i < n && a; i++)
        begin
            u_master.send(8'h30 + i[7:0], a);
            acks += int'(a);
        end
        u_master.stop();
    endtask
    task automatic wait_busy(input logic want, output int t);
        for (int k = 0; k < 3000 && busy !== want; k++)
            @(negedge core_clk);
        t = cyc;
    endtask
    task automatic t_page;
        int acks;
        int t0;
        int t1;
        frame(8'ha6, 17, acks);
        chk("page acks", 19, acks);
        wait_busy(1'b1, t0);
        chk("busy after stop", 1, busy);
        frame(8'ha0, -1, acks);
        chk("poll while busy", 0, acks);
        wait_busy(1'b0, t1);
        chk("prog time", 1, t1 - t0 <= PROG && t1 - t0 > 300);
        repeat (3) @(negedge core_clk);
        chk("standby after prog", 1, standby);
        frame(8'ha0, -1, acks);
        chk("poll after prog", 1, acks);
        $display("test page done");
    endtask
    task automatic t_addr;
        int acks;
        logic [7:0] bad_sa [3] = '{8'hb0, 8'ha8, 8'h20};
        foreach (bad_sa[i])
        begin
            frame(bad_sa[i], -1, acks);
            chk("foreign address", 0, acks);
        end
        frame(8'ha1, -1, acks);
        chk("read select", 1, acks);
        @(posedge core_clk);
        strap <= 1'b1;
        frame(8'ha8, -1, acks);
        chk("strap match", 1, acks);
        frame(8'ha0, -1, acks);
        chk("strap miss", 0, acks);
        @(posedge core_clk);
        strap <= 1'b0;
        $display("test addressing done");
    endtask
    task automatic t_wp;
        int acks;
        int hit = 0;
        @(posedge core_clk);
        wp <= 1'b1;
        frame(8'ha2, 3, acks);
        chk("protected acks", 5, acks);
        repeat (100)
        begin
            @(negedge core_clk);
            hit += int'(busy !== 1'b0);
        end
        chk("protected prog", 0, hit);
        @(posedge core_clk);
        wp <= 1'b0;
        $display("test protect done");
    endtask
    task automatic t_reset;
        int acks;
        int t0;
        frame(8'ha0, 1, acks);
        wait_busy(1'b1, t0);
        @(posedge core_clk);
        reset_n <= 1'b0;
        @(negedge core_clk);
        chk("busy in reset", 0, busy);
        chk("standby in reset", 1, standby);
        @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(negedge core_clk);
        frame(8'ha0, -1, acks);
        chk("ack after reset", 1, acks);
        $display("test reset done");
    endtask
    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Ceiling well above the roughly 16000 cycles the tests need
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            bad_count++;
            finish_test();
        end
    end
    initial
    begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_page();
        t_addr();
        t_wp();
        t_reset();
        finish_test();
    end
endmodule
